// ### shared/host_service_regs.svh
`ifndef HOST_SERVICE_REGS_SVH
`define HOST_SERVICE_REGS_SVH

// Host command codes
`define CMD_SET_CLOCK    32'h204e0002
`define CMD_CHALLENGE    32'h204e0003
`define CMD_KEY_LIST     32'h204e0004
`define CMD_PARAMS       32'h204e0005
`define CMD_REBOOT       32'h204e0006
`define CMD_UTC_TIME     32'h204e001c
`define CMD_SET_OFFSET   32'h204e001d
`define CMD_LOCAL_TIME   32'h204e001e
`define CMD_OFFSETS      32'h204e0020
`define CMD_DIAG         32'h204e0026
`define CMD_LOG_READ     32'h204e0028
`define CMD_TEMPLATE     32'h204e002e

// Status words
`define STATUS_OK        32'h00000000
`define ERR_UNKNOWN_CMD  32'he0000001
`define ERR_NOT_MFG      32'he0000002

// Reply framing
`define TIME_HI_PAD      8'h00
`define CHAL_LAST_CNT    8'h02
`define OFS_LAST_CNT     8'h02
`define CNT_ONE          8'h01
`define CNT_ZERO         8'h00

// Calendar constants, epoch is 2000-01-01 00:00:00
`define SECS_PER_DAY     32'h00015180
`define SECS_PER_HOUR    32'h00000e10
`define SECS_PER_MIN     32'h0000003c
`define DAYS_YEAR        16'h016d
`define DAYS_LEAP        16'h016e
`define TIME_CENTURY     8'h20

`endif

// ### shared/host_service_pkg.sv
package host_service_pkg;

  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_OFFSETS = 4'h1,
    OP_TMPL    = 4'h2,
    OP_UTC     = 4'h3,
    OP_LOCAL   = 4'h4,
    OP_KEYS    = 4'h5,
    OP_PARAMS  = 4'h6,
    OP_DIAG    = 4'h7,
    OP_LOG     = 4'h8,
    OP_REBOOT  = 4'h9,
    OP_SETCLK  = 4'ha,
    OP_SETOFS  = 4'hb,
    OP_CHAL    = 4'hc
  } op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SEND = 3'h1,
    S_CONV = 3'h2,
    S_WAIT = 3'h3,
    S_DIAG = 3'h4
  } state_t;

  typedef enum logic [1:0] {
    SRC_KEYS   = 2'h0,
    SRC_PARAMS = 2'h1,
    SRC_LOG    = 2'h2,
    SRC_TMPL   = 2'h3
  } src_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_DAY  = 3'h1,
    C_YEAR = 3'h2,
    C_MON  = 3'h3,
    C_HMS  = 3'h4,
    C_DONE = 3'h5
  } conv_t;

endpackage : host_service_pkg

// ### core/time_digit_converter.sv
`timescale 1ns/1ns
`include "host_service_regs.svh"
module time_digit_converter
  import host_service_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Request
  input  wire logic        start,
  input  wire logic [31:0] secs,
  // Result
  output logic             done,
  output logic [55:0]      digits
);

  conv_t       st_r,   st_nxt;
  logic [31:0] rem_r,  rem_nxt;
  logic [15:0] days_r, days_nxt;
  logic [7:0]  yr_r,   yr_nxt;
  logic [7:0]  mon_r,  mon_nxt;
  logic [7:0]  hr_r,   hr_nxt;
  logic [7:0]  mn_r,   mn_nxt;
  logic [55:0] dig_r,  dig_nxt;
  logic        done_r, done_nxt;
  logic        leap;

  // Two BCD digits of a value below one hundred
  function automatic logic [7:0] bcd2(input logic [7:0] v);
    logic [7:0] t;
    logic [7:0] u;
    t = v / 8'h0a;
    u = v % 8'h0a;
    return {t[3:0], u[3:0]};
  endfunction : bcd2

  // Days in a month, months counted from zero
  function automatic logic [15:0] month_len(input logic [7:0] m, input logic lp);
    case (m)
      8'h01:                      month_len = lp ? 16'h001d : 16'h001c;
      8'h03, 8'h05, 8'h08, 8'h0a: month_len = 16'h001e;
      default:                    month_len = 16'h001f;
    endcase
  endfunction : month_len

  // Every fourth year is leap across 2000..2099
  assign leap = (yr_r[1:0] == 2'h0);

  // Serial subtraction: days, years, months, then hours and minutes
  always_comb begin
    st_nxt   = st_r;
    rem_nxt  = rem_r;
    days_nxt = days_r;
    yr_nxt   = yr_r;
    mon_nxt  = mon_r;
    hr_nxt   = hr_r;
    mn_nxt   = mn_r;
    dig_nxt  = dig_r;
    done_nxt = 1'b0;
    unique case (st_r)
      C_IDLE: begin
        if (start) begin
          rem_nxt  = secs;
          days_nxt = 16'h0000;
          yr_nxt   = 8'h00;
          mon_nxt  = 8'h00;
          hr_nxt   = 8'h00;
          mn_nxt   = 8'h00;
          st_nxt   = C_DAY;
        end
      end
      C_DAY: begin
        if (rem_r >= `SECS_PER_DAY) begin
          rem_nxt  = rem_r - `SECS_PER_DAY;
          days_nxt = days_r + 16'h0001;
        end else begin
          st_nxt = C_YEAR;
        end
      end
      C_YEAR: begin
        if (days_r >= (leap ? `DAYS_LEAP : `DAYS_YEAR)) begin
          days_nxt = days_r - (leap ? `DAYS_LEAP : `DAYS_YEAR);
          yr_nxt   = yr_r + 8'h01;
        end else begin
          st_nxt = C_MON;
        end
      end
      C_MON: begin
        if (days_r >= month_len(mon_r, leap)) begin
          days_nxt = days_r - month_len(mon_r, leap);
          mon_nxt  = mon_r + 8'h01;
        end else begin
          st_nxt = C_HMS;
        end
      end
      C_HMS: begin
        if (rem_r >= `SECS_PER_HOUR) begin
          rem_nxt = rem_r - `SECS_PER_HOUR;
          hr_nxt  = hr_r + 8'h01;
        end else if (rem_r >= `SECS_PER_MIN) begin
          rem_nxt = rem_r - `SECS_PER_MIN;
          mn_nxt  = mn_r + 8'h01;
        end else begin
          st_nxt = C_DONE;
        end
      end
      C_DONE: begin
        dig_nxt = {`TIME_CENTURY, bcd2(yr_r), bcd2(mon_r + 8'h01),
                   bcd2(days_r[7:0] + 8'h01), bcd2(hr_r), bcd2(mn_r), bcd2(rem_r[7:0])};
        done_nxt = 1'b1;
        st_nxt  = C_IDLE;
      end
      default: st_nxt = C_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r   <= C_IDLE;
      rem_r  <= 32'h00000000;
      days_r <= 16'h0000;
      yr_r   <= 8'h00;
      mon_r  <= 8'h00;
      hr_r   <= 8'h00;
      mn_r   <= 8'h00;
      dig_r  <= 56'h0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      rem_r  <= rem_nxt;
      days_r <= days_nxt;
      yr_r   <= yr_nxt;
      mon_r  <= mon_nxt;
      hr_r   <= hr_nxt;
      mn_r   <= mn_nxt;
      dig_r  <= dig_nxt;
      done_r <= done_nxt;
    end
  end

  // Done rises with the fresh digits, never alongside the stale ones
  assign digits = dig_r;
  assign done   = done_r;

endmodule : time_digit_converter

// ### core/host_service_command_decoder.sv
`timescale 1ns/1ns
`include "host_service_regs.svh"
module host_service_command_decoder
  import host_service_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Command from host
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [31:0] cmd_code,
  input  wire logic [55:0] cmd_arg,
  input  wire logic        param_all,
  input  wire logic [7:0]  param_id,
  // Reply to host
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic [31:0]      rsp_data,
  output logic             rsp_last,
  // Record store read port
  output src_t             store_src,
  output logic             store_req,
  output logic [7:0]       store_idx,
  input  wire logic [7:0]  store_len,
  input  wire logic        store_valid,
  input  wire logic [31:0] store_data,
  // Random bit generator
  output logic             rng_req,
  input  wire logic        rng_valid,
  input  wire logic [31:0] rng_data,
  // Real-time clock
  input  wire logic [31:0] rtc_seconds,
  input  wire logic [31:0] drift_value,
  input  wire logic        mfg_state,
  output logic             rtc_load,
  output logic [55:0]      rtc_load_digits,
  output logic [31:0]      time_zone_offset,
  // Diagnostics and restart
  output logic             diag_start,
  input  wire logic        diag_done,
  input  wire logic [31:0] diag_err,
  output logic             reboot_req
);

  state_t      state_r, state_nxt;
  op_t         op_r,    op_nxt;
  op_t         dec_op;
  op_t         op_sel;
  logic [7:0]  cnt_r,   cnt_nxt;
  logic [7:0]  nc;
  logic [31:0] word_r,  word_nxt;
  logic        last_r,  last_nxt;
  logic [31:0] ofs_r,   ofs_nxt;
  logic        pall_r,  pall_nxt;
  logic [7:0]  pid_r,   pid_nxt;
  logic [7:0]  idx_r,   idx_nxt;
  logic        sreq_r,  sreq_nxt;
  logic        rreq_r,  rreq_nxt;
  logic        load_r,  load_nxt;
  logic [55:0] ldig_r,  ldig_nxt;
  logic        diag_r,  diag_nxt;
  logic        boot_r,  boot_nxt;
  logic        pall_sel;
  logic [7:0]  fetch_len;
  logic        conv_go;
  logic        conv_done;
  logic [55:0] conv_digits;
  logic [31:0] conv_secs;

  // Map a command code to a service
  always_comb begin
    unique case (cmd_code)
      `CMD_OFFSETS:    dec_op = OP_OFFSETS;
      `CMD_TEMPLATE:   dec_op = OP_TMPL;
      `CMD_UTC_TIME:   dec_op = OP_UTC;
      `CMD_LOCAL_TIME: dec_op = OP_LOCAL;
      `CMD_KEY_LIST:   dec_op = OP_KEYS;
      `CMD_PARAMS:     dec_op = OP_PARAMS;
      `CMD_DIAG:       dec_op = OP_DIAG;
      `CMD_LOG_READ:   dec_op = OP_LOG;
      `CMD_REBOOT:     dec_op = OP_REBOOT;
      `CMD_SET_CLOCK:  dec_op = OP_SETCLK;
      `CMD_SET_OFFSET: dec_op = OP_SETOFS;
      `CMD_CHALLENGE:  dec_op = OP_CHAL;
      default:         dec_op = OP_NONE;
    endcase
  end

  // Store source follows the decoded command while idle
  assign op_sel   = (state_r == S_IDLE) ? dec_op : op_r;
  assign pall_sel = (state_r == S_IDLE) ? param_all : pall_r;
  always_comb begin
    unique case (op_sel)
      OP_TMPL:   store_src = SRC_TMPL;
      OP_PARAMS: store_src = SRC_PARAMS;
      OP_LOG:    store_src = SRC_LOG;
      default:   store_src = SRC_KEYS;
    endcase
  end

  // A single named parameter is one word, otherwise the store length
  assign fetch_len = (op_sel == OP_PARAMS && !pall_sel) ? `CNT_ONE : store_len;

  // Time base for conversion: drift always, offset for local forms
  assign conv_secs = rtc_seconds + drift_value +
                     ((op_r == OP_UTC) ? 32'h00000000 : ofs_r);

  assign nc = cnt_r + `CNT_ONE;

  // Command sequencer
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    cnt_nxt   = cnt_r;
    word_nxt  = word_r;
    last_nxt  = last_r;
    ofs_nxt   = ofs_r;
    pall_nxt  = pall_r;
    pid_nxt   = pid_r;
    idx_nxt   = idx_r;
    sreq_nxt  = 1'b0;
    rreq_nxt  = 1'b0;
    load_nxt  = 1'b0;
    ldig_nxt  = ldig_r;
    diag_nxt  = 1'b0;
    boot_nxt  = 1'b0;
    conv_go   = 1'b0;
    unique case (state_r)
      S_IDLE: begin
        if (cmd_valid) begin
          op_nxt    = dec_op;
          cnt_nxt   = `CNT_ZERO;
          pall_nxt  = param_all;
          pid_nxt   = param_id;
          word_nxt  = `STATUS_OK;
          last_nxt  = 1'b0;
          state_nxt = S_SEND;
          unique case (dec_op)
            OP_REBOOT: begin
              boot_nxt  = 1'b1;
              state_nxt = S_IDLE;
            end
            OP_DIAG: begin
              diag_nxt  = 1'b1;
              state_nxt = S_DIAG;
            end
            OP_SETCLK: begin
              last_nxt = 1'b1;
              if (mfg_state) begin
                load_nxt = 1'b1;
                ldig_nxt = cmd_arg;
              end else begin
                word_nxt = `ERR_NOT_MFG;
              end
            end
            OP_SETOFS: ofs_nxt = cmd_arg[31:0];
            OP_NONE: begin
              word_nxt = `ERR_UNKNOWN_CMD;
              last_nxt = 1'b1;
            end
            OP_KEYS, OP_PARAMS, OP_LOG, OP_TMPL: begin
              last_nxt = (fetch_len == `CNT_ZERO);
            end
            default: ;
          endcase
        end
      end
      S_SEND: begin
        if (rsp_ready) begin
          cnt_nxt = nc;
          if (last_r) begin
            state_nxt = S_IDLE;
          end else begin
            unique case (op_r)
              OP_OFFSETS: begin
                word_nxt = (nc == `CNT_ONE) ? drift_value : ofs_r;
                last_nxt = (nc == `OFS_LAST_CNT);
              end
              OP_UTC, OP_LOCAL, OP_SETOFS: begin
                if (nc == `CNT_ONE) begin
                  conv_go   = 1'b1;
                  state_nxt = S_CONV;
                end else begin
                  word_nxt = conv_digits[31:0];
                  last_nxt = 1'b1;
                end
              end
              OP_KEYS, OP_PARAMS, OP_LOG, OP_TMPL: begin
                idx_nxt   = (op_r == OP_PARAMS && !pall_r) ? pid_r : cnt_r;
                sreq_nxt  = 1'b1;
                state_nxt = S_WAIT;
              end
              OP_CHAL: begin
                rreq_nxt  = 1'b1;
                state_nxt = S_WAIT;
              end
              default: state_nxt = S_IDLE;
            endcase
          end
        end
      end
      S_CONV: begin
        if (conv_done) begin
          word_nxt  = {`TIME_HI_PAD, conv_digits[55:32]};
          state_nxt = S_SEND;
        end
      end
      S_WAIT: begin
        if (op_r == OP_CHAL) begin
          if (rng_valid) begin
            word_nxt  = rng_data;
            last_nxt  = (cnt_r == `CHAL_LAST_CNT);
            state_nxt = S_SEND;
          end
        end else if (store_valid) begin
          word_nxt  = store_data;
          last_nxt  = (cnt_r == fetch_len);
          state_nxt = S_SEND;
        end
      end
      S_DIAG: begin
        if (diag_done) begin
          word_nxt  = (diag_err == `STATUS_OK) ? `STATUS_OK : diag_err;
          last_nxt  = 1'b1;
          state_nxt = S_SEND;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      op_r    <= OP_NONE;
      cnt_r   <= `CNT_ZERO;
      word_r  <= `STATUS_OK;
      last_r  <= 1'b0;
      ofs_r   <= 32'h00000000;
      pall_r  <= 1'b0;
      pid_r   <= 8'h00;
      idx_r   <= 8'h00;
      sreq_r  <= 1'b0;
      rreq_r  <= 1'b0;
      load_r  <= 1'b0;
      ldig_r  <= 56'h0;
      diag_r  <= 1'b0;
      boot_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      cnt_r   <= cnt_nxt;
      word_r  <= word_nxt;
      last_r  <= last_nxt;
      ofs_r   <= ofs_nxt;
      pall_r  <= pall_nxt;
      pid_r   <= pid_nxt;
      idx_r   <= idx_nxt;
      sreq_r  <= sreq_nxt;
      rreq_r  <= rreq_nxt;
      load_r  <= load_nxt;
      ldig_r  <= ldig_nxt;
      diag_r  <= diag_nxt;
      boot_r  <= boot_nxt;
    end
  end

  // Seconds to calendar digits
  time_digit_converter u_conv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (conv_go),
    .secs    (conv_secs),
    .done    (conv_done),
    .digits  (conv_digits)
  );

  // Outputs
  assign cmd_ready        = (state_r == S_IDLE);
  assign rsp_valid        = (state_r == S_SEND);
  assign rsp_data         = word_r;
  assign rsp_last         = last_r;
  assign store_req        = sreq_r;
  assign store_idx        = idx_r;
  assign rng_req          = rreq_r;
  assign rtc_load         = load_r;
  assign rtc_load_digits  = ldig_r;
  assign time_zone_offset = ofs_r;
  assign diag_start       = diag_r;
  assign reboot_req       = boot_r;

endmodule : host_service_command_decoder

// ### sim/host_service_partner.sv
`timescale 1ns/1ns
module host_service_partner
  import host_service_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Record store
  input  wire src_t        store_src,
  input  wire logic        store_req,
  input  wire logic [7:0]  store_idx,
  output logic [7:0]       store_len,
  output logic             store_valid,
  output logic [31:0]      store_data,
  // Random words
  input  wire logic        rng_req,
  output logic             rng_valid,
  output logic [31:0]      rng_data,
  // Diagnostics
  input  wire logic        diag_start,
  output logic             diag_done,
  output logic [31:0]      diag_err,
  input  wire logic        diag_fail
);
  logic [31:0] cnt_r;
  logic [2:0]  dq_r;

  // Lengths grow with the source number, so each source is told apart
  assign store_len = 8'(store_src) + 8'h01;
  // Test outcome chosen by the bench
  assign diag_err = diag_fail ? 32'he00000a5 : 32'h00000000;

  // Store and random words answer one cycle after a request, diag_done four after diag_start; idle data keeps toggling
  always @(posedge clk) begin
    if (sys_rst) begin
      store_valid <= 1'b0;
      rng_valid   <= 1'b0;
      store_data  <= 32'h00000000;
      rng_data    <= 32'h00000000;
      cnt_r       <= 32'h00000000;
      dq_r        <= 3'h0;
      diag_done   <= 1'b0;
    end else begin
      store_valid <= store_req;
      store_data  <= store_req ? {22'h0, store_src, store_idx} : ~store_data;
      rng_valid   <= rng_req;
      rng_data    <= rng_req ? 32'hc0de0000 + cnt_r : ~rng_data;
      cnt_r       <= cnt_r + 32'(rng_req);
      dq_r        <= {dq_r[1:0], diag_start};
      diag_done   <= dq_r[2];
    end
  end
endmodule : host_service_partner

// ### sim/host_service_command_decoder_chk.sv
`timescale 1ns/1ns
`include "host_service_regs.svh"
module host_service_command_decoder_chk (
  // Watched ports
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [31:0] cmd_code,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic [31:0] rsp_data,
  input wire logic        rsp_last,
  input wire logic        reboot_req,
  input wire logic        diag_start,
  input wire logic        diag_done,
  input wire logic [31:0] diag_err,
  input wire logic        mfg_state,
  input wire logic        rtc_load,
  input wire logic [31:0] time_zone_offset
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Command accepted, and an ok first word
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_ok;
    rsp_valid && rsp_data == `STATUS_OK;
  endsequence

  property p_offs;
    s_take ##0 cmd_code == `CMD_OFFSETS |=> s_ok ##0 !rsp_last;
  endproperty
  a_offs: assert property (p_offs) else $error("offsets status wrong");
  property p_reboot;
    s_take ##0 cmd_code == `CMD_REBOOT |=> reboot_req && !rsp_valid;
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot not raised");
  property p_diag;
    s_take ##0 cmd_code == `CMD_DIAG |=> diag_start && !rsp_valid;
  endproperty
  a_diag: assert property (p_diag) else $error("diag not started");
  property p_diag_rsp;
    diag_done && !cmd_ready && !rsp_valid |=> rsp_valid && rsp_data == $past(diag_err);
  endproperty
  a_diag_rsp: assert property (p_diag_rsp) else $error("diag status wrong");
  property p_clk_no;
    s_take ##0 cmd_code == `CMD_SET_CLOCK && !mfg_state
      |=> rsp_data == `ERR_NOT_MFG && rsp_last ##0 (!rtc_load)[*3];
  endproperty
  a_clk_no: assert property (p_clk_no) else $error("clock set outside mfg");
  property p_clk_ok;
    s_take ##0 cmd_code == `CMD_SET_CLOCK && mfg_state |=> s_ok ##[0:2] rtc_load;
  endproperty
  a_clk_ok: assert property (p_clk_ok) else $error("clock load missing");
  property p_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last);
  endproperty
  a_hold: assert property (p_hold) else $error("reply word not held");
  property p_chal;
    s_take ##0 cmd_code == `CMD_CHALLENGE |=> s_ok ##0 !rsp_last;
  endproperty
  a_chal: assert property (p_chal) else $error("challenge status wrong");
  property p_unk;
    s_take ##0 cmd_code == 32'h204e0021
      |=> rsp_data == `ERR_UNKNOWN_CMD && rsp_last && $stable(time_zone_offset);
  endproperty
  a_unk: assert property (p_unk) else $error("unknown code not refused");
  property p_ofs;
    s_take ##0 cmd_code == `CMD_SET_OFFSET |=> s_ok ##0 !rsp_last;
  endproperty
  a_ofs: assert property (p_ofs) else $error("set offset status wrong");
endmodule : host_service_command_decoder_chk

bind host_service_command_decoder host_service_command_decoder_chk chk_u (
  .clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_code, .rsp_valid, .rsp_ready,
  .rsp_data, .rsp_last, .reboot_req, .diag_start, .diag_done, .diag_err,
  .mfg_state, .rtc_load, .time_zone_offset
);

// ### sim/host_service_command_decoder_bench.sv
`timescale 1ns/1ns
`include "host_service_regs.svh"
module host_service_command_decoder_bench
  import host_service_pkg::*;
;
  logic clk = 0, sys_rst = 1, cmd_valid = 0, param_all = 1, rsp_ready = 1, mfg_state = 0;
  logic diag_fail = 0, cmd_ready, rsp_valid, rsp_last, store_req, store_valid;
  logic rng_req, rng_valid, rtc_load, diag_start, diag_done, reboot_req;
  logic [31:0] cmd_code = 0, rtc_seconds = 0, drift_value = 32'h0000003d;
  logic [31:0] rsp_data, store_data, rng_data, time_zone_offset, diag_err;
  logic [55:0] cmd_arg = 0, rtc_load_digits, ld;
  logic [7:0]  param_id = 0, store_idx, store_len;
  src_t        store_src;
  int          failures, tests_run, loads, boots;

  // Clock at 25 MHz
  always #20 clk = ~clk;

  host_service_command_decoder dut_u (.clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_code,
    .cmd_arg, .param_all, .param_id, .rsp_valid, .rsp_ready, .rsp_data, .rsp_last,
    .store_src, .store_req, .store_idx, .store_len, .store_valid, .store_data, .rng_req,
    .rng_valid, .rng_data, .rtc_seconds, .drift_value, .mfg_state, .rtc_load,
    .rtc_load_digits, .time_zone_offset, .diag_start, .diag_done, .diag_err, .reboot_req);
  host_service_partner far_u (.clk, .sys_rst, .store_src, .store_req, .store_idx,
    .store_len, .store_valid, .store_data, .rng_req, .rng_valid, .rng_data,
    .diag_start, .diag_done, .diag_err, .diag_fail);

  // Counts clock loads and restart pulses
  always @(posedge clk) begin
    if (rtc_load === 1'b1) begin
      loads++;
      ld = rtc_load_digits;
    end
    if (reboot_req === 1'b1) boots++;
  end

  task chk(string n, logic [55:0] s, logic [55:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task results;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Offers one command once the block is idle
  task cmd(logic [31:0] c);
    int k;
    k = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    cmd_code = c;
    cmd_valid = 1;
    @(negedge clk);
    cmd_valid = 0;
  endtask : cmd

  // Waits for a reply word and takes it
  task word(string n, logic [31:0] e, logic l);
    int k;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chk(n, {rsp_last, rsp_data}, {l, e});
    @(negedge clk);
  endtask : word

  task t_offsets;
    cmd(`CMD_OFFSETS);
    rsp_ready = 0;
    repeat (3) @(negedge clk);
    rsp_ready = 1;
    word("ofs status", 0, 0);
    word("ofs drift", 32'h3d, 0);
    word("ofs zone", 0, 1);
    $display("offsets done");
  endtask : t_offsets

  task t_store;
    logic [31:0] codes[4];
    codes = '{`CMD_KEY_LIST, `CMD_PARAMS, `CMD_LOG_READ, `CMD_TEMPLATE};
    for (int i = 0; i < 4; i++) begin
      cmd(codes[i]);
      word("store status", 0, 0);
      for (int j = 0; j <= i; j++) word("store word", {22'h0, 2'(i), 8'(j)}, j == i);
    end
    param_all = 0;
    param_id = 8'h07;
    cmd(`CMD_PARAMS);
    word("param status", 0, 0);
    word("param one", 32'h107, 1);
    param_all = 1;
    $display("store done");
  endtask : t_store

  task t_time;
    cmd_arg = 56'h0e10;
    cmd(`CMD_SET_OFFSET);
    word("setofs status", 0, 0);
    word("setofs hi", 32'h00200001, 0);
    word("setofs lo", 32'h01010101, 1);
    chk("zone", time_zone_offset, 32'h0e10);
    cmd(`CMD_LOCAL_TIME);
    word("local status", 0, 0);
    word("local hi", 32'h00200001, 0);
    word("local lo", 32'h01010101, 1);
    cmd(`CMD_UTC_TIME);
    word("utc status", 0, 0);
    word("utc hi", 32'h00200001, 0);
    word("utc lo", 32'h01000101, 1);
    rtc_seconds = 32'h004f1a00;
    cmd(`CMD_UTC_TIME);
    word("leap status", 0, 0);
    word("leap hi", 32'h00200003, 0);
    word("leap lo", 32'h01000101, 1);
    $display("time done");
  endtask : t_time

  task t_misc;
    cmd(`CMD_CHALLENGE);
    word("chal status", 0, 0);
    word("nonce a", 32'hc0de0000, 0);
    word("nonce b", 32'hc0de0001, 1);
    for (int f = 0; f < 2; f++) begin
      diag_fail = f[0];
      cmd(`CMD_DIAG);
      word("diag", f ? 32'he00000a5 : 0, 1);
    end
    cmd(32'h204e0021);
    word("unknown", `ERR_UNKNOWN_CMD, 1);
    chk("zone kept", time_zone_offset, 32'h0e10);
    $display("misc done");
  endtask : t_misc

  task t_clock;
    cmd_arg = 56'h20240229123456;
    mfg_state = 1;
    cmd(`CMD_SET_CLOCK);
    word("setclk ok", 0, 1);
    repeat (2) @(negedge clk);
    chk("load count", loads, 1);
    chk("load digits", ld, 56'h20240229123456);
    mfg_state = 0;
    cmd(`CMD_SET_CLOCK);
    word("setclk refused", `ERR_NOT_MFG, 1);
    repeat (2) @(negedge clk);
    chk("no load", loads, 1);
    cmd(`CMD_REBOOT);
    repeat (4) @(negedge clk);
    chk("reboot", {boots[7:0], rsp_valid, cmd_ready}, {8'h01, 1'b0, 1'b1});
    $display("clock done");
  endtask : t_clock

  // Watchdog against a hung handshake
  initial begin
    #2000000;
    failures++;
    results();
  end

  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 0;
    chk("reset", {rsp_valid, cmd_ready, time_zone_offset}, {1'b0, 1'b1, 32'h0});
    t_offsets();
    t_store();
    t_time();
    t_misc();
    t_clock();
    results();
  end
endmodule : host_service_command_decoder_bench
